// *** core/atps_map.svh ***
// Purpose: offsets, field positions, reset values and timing counts of the timer block
// Assumes: 8-bit I/O register port, 6-bit I/O offsets
// Notes: data-space address of a register is its I/O offset plus 0x20
`ifndef ATPS_MAP_SVH
`define ATPS_MAP_SVH
`define ATPS_DATA_SPACE_OFS 8'h20
`define ATPS_TIMER_CONTROL_OFS 6'h33
`define ATPS_COUNTER_VALUE_OFS 6'h32
`define ATPS_COMPARE_VALUE_OFS 6'h31
`define ATPS_ASYNC_STATUS_OFS 6'h30
`define ATPS_SPECIAL_FUNC_OFS 6'h20
`define ATPS_TIMER_FLAGS_OFS 6'h36
`define ATPS_RESET_BYTE 8'h00
// control field positions
`define ATPS_CTL_FORCE 7
`define ATPS_CTL_WAVE_HI 6
`define ATPS_CTL_OUT_HI 5
`define ATPS_CTL_OUT_LO 4
`define ATPS_CTL_WAVE_LO 3
// async status field positions
`define ATPS_STS_ASYNC_SEL 3
`define ATPS_STS_COUNTER_BUSY 2
`define ATPS_STS_COMPARE_BUSY 1
`define ATPS_STS_CONTROL_BUSY 0
// special function and flag field positions
`define ATPS_SFR_PRESCALER_RESET 0
`define ATPS_FLG_COMPARE 1
`define ATPS_FLG_OVERFLOW 0
// oscillator edges before a held write lands, cpu cycles of flag crossing
`define ATPS_XFER_EDGES 2'd2
`define ATPS_FLAG_SYNC_CYCLES 3
`endif

// *** core/atps_pkg.sv ***
// Purpose: types shared by the timer prescaler block
// Assumes: nothing beyond the map header
// Notes: holding slots are indexed by atps_slot_t
package atps_pkg;
    typedef enum logic [2:0] {
        ATPS_CS_STOP = 3'b000,
        ATPS_CS_DIV1 = 3'b001,
        ATPS_CS_DIV8 = 3'b010,
        ATPS_CS_DIV32 = 3'b011,
        ATPS_CS_DIV64 = 3'b100,
        ATPS_CS_DIV128 = 3'b101,
        ATPS_CS_DIV256 = 3'b110,
        ATPS_CS_DIV1024 = 3'b111
    } atps_clk_sel_t;
    typedef enum logic [1:0] {
        ATPS_SLOT_COUNTER = 2'b00,
        ATPS_SLOT_COMPARE = 2'b01,
        ATPS_SLOT_CONTROL = 2'b10
    } atps_slot_t;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } atps_io_req_t;
endpackage

// *** core/atps_timer.sv ***
// Purpose: eight-bit timer clocking: prescaler, async holding registers, read/flag sync
// Assumes: osc_in_pin_in sampled on core_clk_in, which runs over four times the crystal rate
// Notes: the oscillator domain is emulated with edge enables on the single core clock
`timescale 1ns/1ps
`default_nettype none
`include "atps_map.svh"
// Functional notes
// - tick enables core clock; oscillator replaces it async
// - held write lands after two oscillator edges
// - separate holding register per async register
// - compare match suppressed while counter/compare pending
// - wake logic rearms after one oscillator cycle
// - oscillator stops in power-down, standby, and whenever async select is clear
// - wake starts on next timer tick
// - counter reads from shadow refreshed per edge
// - async flag crossing: three cycles plus tick
// - compare output changes on timer tick directly
// - source clock defaults core, async select oscillator
// - async select detaches both oscillator pins
// - prescaler offers 8..1024, undivided and stop
// - prescaler reset bit clears divider
// - control at 0x33 / 0x53, resets zero
// - clock-select codes decode stop..1024
// - force compare strobe, reads zero
module atps_timer
    import atps_pkg::*;
(
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // i/o register port
    input wire atps_io_req_t io_req_in,
    output logic [7:0] rd_data_out,
    // oscillator pin and power state
    input wire logic osc_in_pin_in,
    input wire logic deep_sleep_in,
    input wire logic power_save_in,
    // pin control, output and status
    output logic port_detach_out,
    output logic osc_enable_out,
    output logic compare_output_pin_out,
    output logic compare_flag_out,
    output logic overflow_flag_out,
    output logic wake_out
);
    logic osc_s1_reg, osc_s2_reg, osc_s3_reg;
    logic osc_rise;
    logic async_clock_select_reg;
    logic [9:0] prescale_reg;
    logic src_tick, timer_tick;
    logic [7:0] counter_value_reg, compare_value_reg, timer_control_reg, counter_shadow_reg;
    logic [7:0] hold_reg [3];
    logic [1:0] edge_cnt_reg [3];
    logic [2:0] busy_reg;
    logic [2:0] land;
    logic [2:0] wr_slot;
    logic force_pending_reg;
    logic write_block_reg;
    logic match, overflow, ctc_mode, non_pwm;
    logic [2:0] cmp_pipe_reg, ovf_pipe_reg;
    logic wake_req_reg, wake_block_reg;
    atps_clk_sel_t clk_sel;
    logic [7:0] rd_next;

    // two-stage synchroniser; stages two and three feed the edge detector
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            osc_s1_reg <= 1'b0;
            osc_s2_reg <= 1'b0;
            osc_s3_reg <= 1'b0;
        end else begin
            osc_s1_reg <= osc_in_pin_in;
            osc_s2_reg <= osc_s1_reg;
            osc_s3_reg <= osc_s2_reg;
        end
    end
    // edges are ignored while the oscillator is halted in deep sleep
    assign osc_rise = osc_s2_reg & ~osc_s3_reg & ~deep_sleep_in;

    // async select lives in the status register; reset picks the core clock
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            async_clock_select_reg <= 1'b0;
        end else if (io_req_in.wr && io_req_in.addr == `ATPS_ASYNC_STATUS_OFS) begin
            async_clock_select_reg <= io_req_in.wdata[`ATPS_STS_ASYNC_SEL];
        end
    end
    assign src_tick = async_clock_select_reg ? osc_rise : 1'b1;

    // free-running divider over the source clock; a reset write restarts its phase
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prescale_reg <= 10'h000;
        end else if (io_req_in.wr && io_req_in.addr == `ATPS_SPECIAL_FUNC_OFS
                     && io_req_in.wdata[`ATPS_SFR_PRESCALER_RESET]) begin
            prescale_reg <= 10'h000;
        end else if (src_tick) begin
            prescale_reg <= prescale_reg + 10'h001;
        end
    end

    // select decode: a divided tick fires when the low divider bits are all ones
    assign clk_sel = atps_clk_sel_t'(timer_control_reg[2:0]);
    always_comb begin
        unique case (clk_sel)
            ATPS_CS_STOP: timer_tick = 1'b0;
            ATPS_CS_DIV1: timer_tick = src_tick;
            ATPS_CS_DIV8: timer_tick = src_tick & (&prescale_reg[2:0]);
            ATPS_CS_DIV32: timer_tick = src_tick & (&prescale_reg[4:0]);
            ATPS_CS_DIV64: timer_tick = src_tick & (&prescale_reg[5:0]);
            ATPS_CS_DIV128: timer_tick = src_tick & (&prescale_reg[6:0]);
            ATPS_CS_DIV256: timer_tick = src_tick & (&prescale_reg[7:0]);
            ATPS_CS_DIV1024: timer_tick = src_tick & (&prescale_reg[9:0]);
        endcase
    end

    // which of the three held registers a write targets
    assign wr_slot[ATPS_SLOT_COUNTER] = io_req_in.wr && io_req_in.addr == `ATPS_COUNTER_VALUE_OFS;
    assign wr_slot[ATPS_SLOT_COMPARE] = io_req_in.wr && io_req_in.addr == `ATPS_COMPARE_VALUE_OFS;
    assign wr_slot[ATPS_SLOT_CONTROL] = io_req_in.wr && io_req_in.addr == `ATPS_TIMER_CONTROL_OFS;

    // one holding slot per register so pending writes never collide
    for (genvar i = 0; i < 3; i++) begin : g_hold
        // sync mode lands at once; async waits for the second oscillator edge
        assign land[i] = async_clock_select_reg
            ? (busy_reg[i] && osc_rise && edge_cnt_reg[i] == `ATPS_XFER_EDGES - 2'd1)
            : wr_slot[i];
        always_ff @(posedge core_clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                hold_reg[i] <= `ATPS_RESET_BYTE;
                edge_cnt_reg[i] <= 2'd0;
                busy_reg[i] <= 1'b0;
            end else if (wr_slot[i]) begin
                // a new write wins over a landing in the same cycle
                hold_reg[i] <= io_req_in.wdata;
                edge_cnt_reg[i] <= 2'd0;
                busy_reg[i] <= async_clock_select_reg;
            end else if (busy_reg[i] && osc_rise) begin
                edge_cnt_reg[i] <= edge_cnt_reg[i] + 2'd1;
                if (land[i]) begin
                    busy_reg[i] <= 1'b0;
                end
            end
        end
    end

    // compare and control destination registers
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            compare_value_reg <= `ATPS_RESET_BYTE;
            timer_control_reg <= `ATPS_RESET_BYTE;
            force_pending_reg <= 1'b0;
        end else begin
            if (land[ATPS_SLOT_COMPARE]) begin
                compare_value_reg <= async_clock_select_reg
                    ? hold_reg[ATPS_SLOT_COMPARE] : io_req_in.wdata;
            end
            if (land[ATPS_SLOT_CONTROL]) begin
                // force bit is a strobe and is never stored
                timer_control_reg <= {1'b0, (async_clock_select_reg
                    ? hold_reg[ATPS_SLOT_CONTROL][6:0] : io_req_in.wdata[6:0])};
            end
            force_pending_reg <= land[ATPS_SLOT_CONTROL] && (async_clock_select_reg
                ? hold_reg[ATPS_SLOT_CONTROL][`ATPS_CTL_FORCE]
                : io_req_in.wdata[`ATPS_CTL_FORCE]);
        end
    end

    assign ctc_mode = timer_control_reg[`ATPS_CTL_WAVE_HI] & ~timer_control_reg[`ATPS_CTL_WAVE_LO];
    assign non_pwm = ~timer_control_reg[`ATPS_CTL_WAVE_LO];
    // no match while a counter or compare write is still in flight
    assign match = timer_tick && counter_value_reg == compare_value_reg && !write_block_reg
        && !busy_reg[ATPS_SLOT_COUNTER] && !busy_reg[ATPS_SLOT_COMPARE];
    assign overflow = timer_tick && counter_value_reg == 8'hFF;

    // counter: a landed write wins over counting and blocks the next tick's match
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            counter_value_reg <= `ATPS_RESET_BYTE;
            write_block_reg <= 1'b0;
        end else if (land[ATPS_SLOT_COUNTER]) begin
            counter_value_reg <= async_clock_select_reg
                ? hold_reg[ATPS_SLOT_COUNTER] : io_req_in.wdata;
            write_block_reg <= 1'b1;
        end else if (timer_tick) begin
            write_block_reg <= 1'b0;
            counter_value_reg <= (ctc_mode && match) ? 8'h00 : counter_value_reg + 8'h01;
        end
    end

    // shadow for reads: every cycle in sync mode, each oscillator edge in async mode
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            counter_shadow_reg <= `ATPS_RESET_BYTE;
        end else if (!async_clock_select_reg || osc_rise) begin
            counter_shadow_reg <= counter_value_reg;
        end
    end

    // output pin acts on the timer tick itself, no extra cpu-clock stage
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            compare_output_pin_out <= 1'b0;
        end else if ((match || (force_pending_reg && non_pwm))
                     && timer_control_reg[5:4] != 2'b00) begin
            unique case (timer_control_reg[5:4])
                2'b01: compare_output_pin_out <= ~compare_output_pin_out;
                2'b10: compare_output_pin_out <= 1'b0;
                2'b11: compare_output_pin_out <= 1'b1;
                default: compare_output_pin_out <= compare_output_pin_out;
            endcase
        end
    end

    // flag crossing: async events travel three extra cpu cycles
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cmp_pipe_reg <= 3'b000;
            ovf_pipe_reg <= 3'b000;
        end else begin
            cmp_pipe_reg <= {cmp_pipe_reg[1:0], match & async_clock_select_reg};
            ovf_pipe_reg <= {ovf_pipe_reg[1:0], overflow & async_clock_select_reg};
        end
    end

    // sticky flags, write one to clear; a set in the same cycle wins
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            compare_flag_out <= 1'b0;
            overflow_flag_out <= 1'b0;
        end else begin
            if ((async_clock_select_reg ? cmp_pipe_reg[2] : match)) begin
                compare_flag_out <= 1'b1;
            end else if (io_req_in.wr && io_req_in.addr == `ATPS_TIMER_FLAGS_OFS
                         && io_req_in.wdata[`ATPS_FLG_COMPARE]) begin
                compare_flag_out <= 1'b0;
            end
            if ((async_clock_select_reg ? ovf_pipe_reg[2] : overflow)) begin
                overflow_flag_out <= 1'b1;
            end else if (io_req_in.wr && io_req_in.addr == `ATPS_TIMER_FLAGS_OFS
                         && io_req_in.wdata[`ATPS_FLG_OVERFLOW]) begin
                overflow_flag_out <= 1'b0;
            end
        end
    end

    // wake: armed by the event, issued on the next timer tick, rearmed one edge later
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wake_req_reg <= 1'b0;
            wake_out <= 1'b0;
            wake_block_reg <= 1'b0;
        end else begin
            wake_out <= 1'b0;
            if ((match || overflow) && async_clock_select_reg && power_save_in) begin
                wake_req_reg <= 1'b1;
            end else if (wake_req_reg && timer_tick) begin
                wake_req_reg <= 1'b0;
                wake_out <= !wake_block_reg;
            end
            if (wake_out) begin
                wake_block_reg <= 1'b1;
            end else if (osc_rise) begin
                wake_block_reg <= 1'b0;
            end
        end
    end

    // pin ownership and oscillator run control
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            port_detach_out <= 1'b0;
            osc_enable_out <= 1'b0;
        end else begin
            port_detach_out <= async_clock_select_reg;
            osc_enable_out <= async_clock_select_reg & ~deep_sleep_in;
        end
    end

    // read mux; unmapped offsets read as zero
    always_comb begin
        unique case (io_req_in.addr)
            `ATPS_TIMER_CONTROL_OFS: rd_next = timer_control_reg;
            `ATPS_COUNTER_VALUE_OFS: rd_next = counter_shadow_reg;
            `ATPS_COMPARE_VALUE_OFS: rd_next = compare_value_reg;
            `ATPS_ASYNC_STATUS_OFS: rd_next = {4'h0, async_clock_select_reg,
                busy_reg[ATPS_SLOT_COUNTER], busy_reg[ATPS_SLOT_COMPARE],
                busy_reg[ATPS_SLOT_CONTROL]};
            `ATPS_TIMER_FLAGS_OFS: rd_next = {6'h00, compare_flag_out, overflow_flag_out};
            default: rd_next = 8'h00;
        endcase
    end
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_data_out <= 8'h00;
        end else if (io_req_in.rd) begin
            rd_data_out <= rd_next;
        end
    end

    chk_busy_on_write: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        wr_slot[ATPS_SLOT_COMPARE] && async_clock_select_reg |=> busy_reg[ATPS_SLOT_COMPARE])
        else $error("busy not set by async write");
    chk_hold_two_edges: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        $fell(busy_reg[ATPS_SLOT_CONTROL]) |-> $past(osc_rise) && $past(edge_cnt_reg[2]) == 2'd1)
        else $error("control landed before second edge");
    chk_match_blocked: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        busy_reg[ATPS_SLOT_COUNTER] || busy_reg[ATPS_SLOT_COMPARE] |-> !match)
        else $error("match while write pending");
    chk_flag_delay: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        match && async_clock_select_reg && !compare_flag_out ##1 async_clock_select_reg [*3]
        |=> compare_flag_out)
        else $error("async compare flag not set three cycles later");
    chk_no_early_flag: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        async_clock_select_reg && $rose(compare_flag_out) |-> $past(cmp_pipe_reg[2]))
        else $error("async compare flag set early");
    chk_shadow_hold: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        async_clock_select_reg && !$past(osc_rise) && $past(async_clock_select_reg)
        |-> $stable(counter_shadow_reg))
        else $error("shadow changed without oscillator edge");
    chk_stop_code: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        clk_sel == ATPS_CS_STOP && !land[ATPS_SLOT_COUNTER] |=> $stable(counter_value_reg))
        else $error("counter moved while stopped");
    chk_div8_phase: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        clk_sel == ATPS_CS_DIV8 && timer_tick |-> prescale_reg[2:0] == 3'h7)
        else $error("divide by 8 tick off phase");
    chk_prescale_reset: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        io_req_in.wr && io_req_in.addr == `ATPS_SPECIAL_FUNC_OFS && io_req_in.wdata[0]
        |=> prescale_reg == 10'h000)
        else $error("prescaler not cleared");
    chk_force_reads_zero: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        timer_control_reg[`ATPS_CTL_FORCE] == 1'b0)
        else $error("force bit stored");
    chk_detach_follow: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        ##1 port_detach_out == $past(async_clock_select_reg))
        else $error("pin detach does not follow async select");
    chk_wake_rearm: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        wake_out |=> !wake_out)
        else $error("wake issued twice back to back");
endmodule
`default_nettype wire

// *** testbench/atps_crystal_model.sv ***
// Purpose: behavioural watch crystal on the timer oscillator pins
// Assumes: half period well above four core clock periods, unrelated in phase
// Notes: the crystal stops and rests low whenever the block turns the oscillator off
`timescale 1ns/1ps
`default_nettype none
module atps_crystal_model #(
    parameter int HALF_NS = 413
) (
    // control from the block and the bench
    input wire logic osc_enable_in,
    input wire logic slow_in,
    // oscillator level into the block
    output logic osc_in_pin_out
);
    initial osc_in_pin_out = 1'b0;
    // free-running only while enabled; slow mode triples the period
    always begin
        if (osc_enable_in === 1'b1) begin
            #(slow_in ? HALF_NS * 3 : HALF_NS);
            osc_in_pin_out = ~osc_in_pin_out;
        end else begin
            osc_in_pin_out = 1'b0; // a stopped crystal does not hold its last swing
            @(osc_enable_in);
        end
    end
endmodule
`default_nettype wire

// *** testbench/test_async_timer_prescaler_sync.sv ***
// Purpose: self-checking bench for the timer prescaler and async holding logic
// Assumes: register port and timing as handed over by the designer
// Notes: counts are checked within a window where the prescaler phase is not visible
`timescale 1ns/1ps
`default_nettype none
`include "atps_map.svh"
module test_async_timer_prescaler_sync;
    import atps_pkg::*;
    logic core_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    atps_io_req_t io_req = '0;
    logic deep_sleep_in = 1'b0;
    logic power_save_in = 1'b0;
    logic slow_in = 1'b0;
    logic osc_in_pin, port_detach_out, osc_enable_out, compare_output_pin_out;
    logic compare_flag_out, overflow_flag_out, wake_out;
    logic [7:0] rd_data_out, rv, rv2;
    int fails = 0;
    int n_checks = 0;
    int cyc = 0;
    atps_timer atps_timer_i (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
        .io_req_in(io_req), .rd_data_out(rd_data_out), .osc_in_pin_in(osc_in_pin),
        .deep_sleep_in(deep_sleep_in), .power_save_in(power_save_in),
        .port_detach_out(port_detach_out), .osc_enable_out(osc_enable_out),
        .compare_output_pin_out(compare_output_pin_out), .compare_flag_out(compare_flag_out),
        .overflow_flag_out(overflow_flag_out), .wake_out(wake_out));
    atps_crystal_model atps_crystal_model_i (.osc_enable_in(osc_enable_out),
        .slow_in(slow_in), .osc_in_pin_out(osc_in_pin));
    // 20 MHz core clock
    always #25 core_clk_in = ~core_clk_in;
    // hang guard, well above the expected run length
    always @(posedge core_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            fails = fails + 1;
            close_out();
        end
    end
    task automatic close_out();
        if (fails == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one-cycle strobes, one idle cycle between requests
    task automatic io_write(input logic [5:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        #2 io_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge core_clk_in);
        #2 io_req = '0;
    endtask
    task automatic io_read(input logic [5:0] a, output logic [7:0] d);
        @(posedge core_clk_in);
        #2 io_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge core_clk_in);
        #2 io_req = '0;
        d = rd_data_out;
    endtask
    task automatic wait_cycles(input int n);
        repeat (n) @(posedge core_clk_in);
        #2;
    endtask
    // wait until no async transfer is pending, bounded
    task automatic wait_idle();
        for (int i = 0; i < 100; i++) begin
            io_read(`ATPS_ASYNC_STATUS_OFS, rv);
            if (rv[2:0] === 3'b000) break;
        end
        check("busy flags idle", {5'b0, rv[2:0]}, 8'h00);
    endtask
    task automatic t_reset();
        io_read(`ATPS_TIMER_CONTROL_OFS, rv);
        check("control reset", rv, `ATPS_RESET_BYTE);
        io_read(`ATPS_ASYNC_STATUS_OFS, rv);
        check("status reset", rv, 8'h00);
        check("detach at reset", {7'b0, port_detach_out}, 8'h00);
    endtask
    // force strobe per output mode: toggle, toggle, set, clear
    task automatic t_force();
        logic [7:0] ctl [4] = '{8'h90, 8'h90, 8'hB0, 8'hA0};
        logic pin [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
        for (int i = 0; i < 4; i++) begin
            io_write(`ATPS_TIMER_CONTROL_OFS, ctl[i]);
            wait_cycles(3);
            check("compare pin", {7'b0, compare_output_pin_out}, {7'b0, pin[i]});
            io_read(`ATPS_TIMER_CONTROL_OFS, rv);
            check("force reads zero", rv, ctl[i] & 8'h7F);
        end
    endtask
    // every clock-select code, counted over eight divided periods
    task automatic t_prescale();
        int div [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
        logic ok;
        for (int cs = 0; cs < 8; cs++) begin
            io_write(`ATPS_TIMER_CONTROL_OFS, 8'h00);
            io_write(`ATPS_COUNTER_VALUE_OFS, 8'h00);
            io_write(`ATPS_SPECIAL_FUNC_OFS, 8'h01);
            io_write(`ATPS_TIMER_CONTROL_OFS, {5'b0, cs[2:0]});
            wait_cycles(cs == 0 ? 64 : 8 * div[cs]);
            io_read(`ATPS_COUNTER_VALUE_OFS, rv);
            ok = (cs == 0) ? (rv === 8'h00) : (rv >= 8'd7 && rv <= 8'd11);
            check("count per select code", {7'b0, ok}, 8'h01);
        end
        // undivided count across 0xff raises the overflow flag, write one clears it
        io_write(`ATPS_COUNTER_VALUE_OFS, 8'hFC);
        io_write(`ATPS_TIMER_CONTROL_OFS, 8'h01);
        wait_cycles(8);
        check("overflow flag", {7'b0, overflow_flag_out}, 8'h01);
        io_write(`ATPS_TIMER_CONTROL_OFS, 8'h00);
        io_write(`ATPS_TIMER_FLAGS_OFS, 8'h03);
        wait_cycles(2);
        check("overflow cleared", {7'b0, overflow_flag_out}, 8'h00);
    endtask
    // two writes held apart, landing after the second oscillator rise
    task automatic t_async();
        io_write(`ATPS_ASYNC_STATUS_OFS, 8'h08);
        wait_cycles(2);
        check("pins detached", {6'b0, port_detach_out, osc_enable_out}, 8'h03);
        @(posedge osc_in_pin);
        wait_cycles(5);
        io_write(`ATPS_COUNTER_VALUE_OFS, 8'h5A);
        io_write(`ATPS_COMPARE_VALUE_OFS, 8'h20);
        io_read(`ATPS_ASYNC_STATUS_OFS, rv);
        check("both busy", rv, 8'h0E);
        @(posedge osc_in_pin);
        wait_cycles(6);
        io_read(`ATPS_ASYNC_STATUS_OFS, rv);
        check("busy after one edge", rv, 8'h0E);
        @(posedge osc_in_pin);
        wait_cycles(6);
        io_read(`ATPS_ASYNC_STATUS_OFS, rv);
        check("landed after two edges", rv, 8'h08);
        // the read shadow only catches the landed value on the next oscillator rise
        @(posedge osc_in_pin);
        wait_cycles(6);
        io_read(`ATPS_COUNTER_VALUE_OFS, rv);
        check("counter shadow", rv, 8'h5A);
    endtask
    // compare match wakes the core in power save, slow crystal
    task automatic t_wake();
        int seen = 0;
        slow_in = 1'b1;
        io_write(`ATPS_COUNTER_VALUE_OFS, 8'h00);
        io_write(`ATPS_COMPARE_VALUE_OFS, 8'h03);
        wait_idle();
        power_save_in = 1'b1;
        io_write(`ATPS_TIMER_CONTROL_OFS, 8'h01);
        for (int i = 0; i < 800 && seen == 0; i++) begin
            @(posedge core_clk_in);
            #2 if (wake_out === 1'b1) seen = 1;
        end
        check("wake pulse", seen[7:0], 8'h01);
        wait_cycles(1);
        check("wake one cycle", {7'b0, wake_out}, 8'h00);
        wait_cycles(8);
        check("compare flag", {7'b0, compare_flag_out}, 8'h01);
        power_save_in = 1'b0;
        io_write(`ATPS_TIMER_FLAGS_OFS, 8'h02);
        wait_cycles(2);
        check("flag cleared", {7'b0, compare_flag_out}, 8'h00);
        // safe counter read after wake: rewrite compare, wait busy, then read
        io_write(`ATPS_COMPARE_VALUE_OFS, 8'h03);
        wait_idle();
        io_read(`ATPS_COUNTER_VALUE_OFS, rv);
        check("counter after wake", {7'b0, rv >= 8'd5 && rv <= 8'd10}, 8'h01);
        slow_in = 1'b0;
    endtask
    // oscillator stops in deep sleep, counter freezes
    task automatic t_deep();
        deep_sleep_in = 1'b1;
        wait_cycles(3);
        check("osc off in deep sleep", {7'b0, osc_enable_out}, 8'h00);
        io_read(`ATPS_COUNTER_VALUE_OFS, rv);
        wait_cycles(200);
        io_read(`ATPS_COUNTER_VALUE_OFS, rv2);
        check("counter frozen", rv2, rv);
        deep_sleep_in = 1'b0;
        wait_cycles(3);
        check("osc back on", {7'b0, osc_enable_out}, 8'h01);
    endtask
    // reset for three cycles, release just after an edge
    initial begin
        repeat (3) @(posedge core_clk_in);
        #2 rst_n_in = 1'b1;
        t_reset();
        t_force();
        t_prescale();
        t_async();
        t_wake();
        t_deep();
        close_out();
    end
endmodule
`default_nettype wire
